// File: hdl/mjp_cfg.svh
// Constants of the jam stage: timing, encodings, reset values and widths.
`ifndef MJP_CFG_SVH
`define MJP_CFG_SVH

`define MJP_CLK_PERIOD_NS   10
`define MJP_STAMP_RES_MS    1
`define MJP_TICK_CYCLES     ((`MJP_STAMP_RES_MS * 1000000) / `MJP_CLK_PERIOD_NS)
`define MJP_SAMPLE_BASE_MS  5
`define MJP_PREFAULT_WIN_MS 20
`define MJP_AVG_DEPTH       (`MJP_PREFAULT_WIN_MS / `MJP_SAMPLE_BASE_MS)
`define MJP_HIST_DEPTH      (2 * `MJP_AVG_DEPTH)
`define MJP_AVG_SHIFT       2

`define MJP_GROUPS          8
`define MJP_MAG_W           16
`define MJP_DELAY_W         21
`define MJP_CNT_W           16
`define MJP_STAMP_W         32

`define MJP_HYST_NUM        23'h00_0061
`define MJP_HYST_DEN        23'h00_0064

`define MJP_THR_RESET       16'h0032
`define MJP_DELAY_RESET     21'h00_0000

`define MJP_LN_ON           3'h1
`define MJP_LN_BLOCKED      3'h2
`define MJP_LN_TEST         3'h3
`define MJP_LN_TEST_BLOCKED 3'h4
`define MJP_LN_OFF          3'h5

`define MJP_FORCE_NORMAL    2'h0
`define MJP_FORCE_START     2'h1
`define MJP_FORCE_TRIP      2'h2
`define MJP_FORCE_BLOCKED   2'h3

`define MJP_SEL_FIRST       2'h1
`define MJP_SEL_SECOND      2'h2

`define MJP_EV_START        0
`define MJP_EV_TRIP         1
`define MJP_EV_BLOCK        2

`endif

// File: hdl/mjp_jam_stage.sv
// Mechanical jam stage: pick-up, definite delay, blocking, events and counters.
`timescale 1ns/1ps
`include "mjp_cfg.svh"
module mjp_jam_stage #(
	parameter int unsigned TICK_CYCLES = `MJP_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                    CLK,
	input  wire logic                    RSTN,
	// Current measurement modules
	input  wire mjp_pkg::mjp_meas_t      CUR_FIRST,
	input  wire mjp_pkg::mjp_meas_t      CUR_SECOND,
	// Motor status and blocking
	input  wire logic                    MOTOR_RUNNING,
	input  wire logic                    MOTOR_STARTING,
	input  wire logic                    BLOCK_IN,
	// Setting groups
	input  wire logic                    GRP_WR,
	input  wire logic [2:0]              GRP_WR_IDX,
	input  wire mjp_pkg::mjp_group_t     GRP_WR_DATA,
	input  wire logic [2:0]              ACTIVE_GROUP,
	// General settings
	input  wire logic                    LN_SET_ENABLE,
	input  wire logic [2:0]              LN_STATE,
	input  wire logic                    FORCE_ENABLE,
	input  wire logic [1:0]              FORCE_STATUS,
	input  wire logic [1:0]              MEAS_SEL,
	input  wire logic                    MULTI_MODULE,
	// Stage outputs
	output logic                         START_OUT,
	output logic                         TRIP_OUT,
	output logic                         BLOCKED_OUT,
	output mjp_pkg::mjp_event_t          EVENT,
	output logic [2:0][`MJP_CNT_W-1:0]   EVENT_COUNT,
	output mjp_pkg::mjp_phase_t          PREFAULT
);
	////////////////////////////////////////////////////////////////////////////
	// Millisecond time base.
	logic [31:0]              tick_cnt_reg;
	logic [31:0]              tick_cnt_next;
	logic [`MJP_STAMP_W-1:0]  stamp_reg;
	logic [`MJP_STAMP_W-1:0]  stamp_next;
	logic                     tick;

	always_comb begin
		tick          = (tick_cnt_reg == TICK_CYCLES - 1);
		tick_cnt_next = tick ? '0 : tick_cnt_reg + 32'h0000_0001;
		stamp_next    = tick ? stamp_reg + 32'h0000_0001 : stamp_reg;
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			tick_cnt_reg <= '0;
			stamp_reg    <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			stamp_reg    <= stamp_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Setting groups and measurement input.
	mjp_pkg::mjp_group_t grp_reg [`MJP_GROUPS];
	mjp_pkg::mjp_group_t grp_next [`MJP_GROUPS];
	mjp_pkg::mjp_group_t grp;
	mjp_pkg::mjp_meas_t  meas;
	mjp_pkg::mjp_phase_t ph_reg;
	mjp_pkg::mjp_phase_t ph_next;

	always_comb begin
		for (int i = 0; i < `MJP_GROUPS; i++) begin
			grp_next[i] = grp_reg[i];
		end
		if (GRP_WR) begin
			grp_next[GRP_WR_IDX] = GRP_WR_DATA;
		end
		grp = grp_reg[ACTIVE_GROUP];
		// The module choice is a general setting, untouched by group changes.
		meas = (MULTI_MODULE && MEAS_SEL == `MJP_SEL_SECOND) ? CUR_SECOND : CUR_FIRST;
		ph_next = meas.valid ? meas.mag : ph_reg;
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < `MJP_GROUPS; i++) begin
				grp_reg[i] <= '{threshold: `MJP_THR_RESET, instant: 1'b0, delay_ms: `MJP_DELAY_RESET};
			end
			ph_reg <= '0;
		end else begin
			for (int i = 0; i < `MJP_GROUPS; i++) begin
				grp_reg[i] <= grp_next[i];
			end
			ph_reg <= ph_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pick-up with fixed hysteresis.
	logic        pick_reg;
	logic        pick_next;
	logic [2:0]  over;
	logic [2:0]  under;
	logic [22:0] rel_lim;

	always_comb begin
		rel_lim = {7'h00, grp.threshold} * `MJP_HYST_NUM;
		for (int p = 0; p < 3; p++) begin
			over[p]  = ph_reg[p] > grp.threshold;
			// Scaled compare keeps the 97 percent exact without a divider.
			under[p] = ({7'h00, ph_reg[p]} * `MJP_HYST_DEN) < rel_lim;
		end
		if (|over) begin
			pick_next = 1'b1;
		end else if (&under) begin
			pick_next = 1'b0;
		end else begin
			pick_next = pick_reg;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pick_reg <= 1'b0;
		end else begin
			pick_reg <= pick_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Stage sequence.
	mjp_pkg::mjp_state_t     state_reg;
	mjp_pkg::mjp_state_t     state_next;
	logic [`MJP_DELAY_W-1:0] timer_reg;
	logic [`MJP_DELAY_W-1:0] timer_next;
	logic [2:0]              ln;
	logic                    act;
	logic                    blk;

	always_comb begin
		ln  = LN_SET_ENABLE ? LN_STATE : `MJP_LN_ON;
		act = MOTOR_RUNNING && !MOTOR_STARTING && ln != `MJP_LN_OFF;
		blk = BLOCK_IN || ln == `MJP_LN_BLOCKED || ln == `MJP_LN_TEST_BLOCKED;
		state_next = state_reg;
		timer_next = timer_reg;
		case (state_reg)
			mjp_pkg::MJP_IDLE: begin
				timer_next = '0;
				if (act && pick_reg) begin
					if (blk) begin
						state_next = mjp_pkg::MJP_BLOCK;
					end else if (grp.instant) begin
						state_next = mjp_pkg::MJP_TRIP;
					end else begin
						state_next = mjp_pkg::MJP_START;
					end
				end
			end
			mjp_pkg::MJP_START: begin
				if (!act || !pick_reg) begin
					state_next = mjp_pkg::MJP_IDLE;
				end else if (blk) begin
					state_next = mjp_pkg::MJP_BLOCK;
				end else if (timer_reg >= grp.delay_ms) begin
					state_next = mjp_pkg::MJP_TRIP;
				end else if (tick) begin
					timer_next = timer_reg + 21'h00_0001;
				end
			end
			mjp_pkg::MJP_TRIP: begin
				if (!act || !pick_reg) begin
					state_next = mjp_pkg::MJP_IDLE;
				end else if (blk) begin
					state_next = mjp_pkg::MJP_BLOCK;
				end
			end
			mjp_pkg::MJP_BLOCK: begin
				if (!act || !pick_reg || !blk) begin
					state_next = mjp_pkg::MJP_IDLE;
				end
			end
			default: begin
				state_next = mjp_pkg::MJP_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_reg <= mjp_pkg::MJP_IDLE;
			timer_reg <= '0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, events and counters; bit 0 start, bit 1 trip, bit 2 blocked.
	logic [2:0]            out_reg;
	logic [2:0]            out_next;
	mjp_pkg::mjp_event_t   evt_reg;
	mjp_pkg::mjp_event_t   evt_next;
	logic [2:0][`MJP_CNT_W-1:0] cnt_reg;
	logic [2:0][`MJP_CNT_W-1:0] cnt_next;

	always_comb begin
		out_next = {state_reg == mjp_pkg::MJP_BLOCK, state_reg == mjp_pkg::MJP_TRIP,
			state_reg == mjp_pkg::MJP_START || state_reg == mjp_pkg::MJP_TRIP};
		if (FORCE_ENABLE) begin
			case (FORCE_STATUS)
				`MJP_FORCE_START:   out_next = 3'b001;
				`MJP_FORCE_TRIP:    out_next = 3'b011;
				`MJP_FORCE_BLOCKED: out_next = 3'b100;
				default:            out_next = out_next;
			endcase
		end
		evt_next.stamp = stamp_reg;
	end

	genvar k;
	generate
		for (k = 0; k < 3; k++) begin : g_evt
			always_comb begin
				evt_next.valid[k] = out_next[k] ^ out_reg[k];
				evt_next.on[k]    = out_next[k];
				cnt_next[k]       = cnt_reg[k] + {{(`MJP_CNT_W-1){1'b0}}, out_next[k] & ~out_reg[k]};
			end
		end
	endgenerate

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			out_reg <= '0;
			evt_reg <= '0;
			cnt_reg <= '0;
		end else begin
			out_reg <= out_next;
			evt_reg <= evt_next;
			cnt_reg <= cnt_next;
		end
	end

	mjp_prefault u_prefault (
		.clk          (CLK),
		.rstn         (RSTN),
		.sample_valid (meas.valid),
		.sample       (meas.mag),
		.capture      ((evt_next.valid[0] & out_next[0]) | (evt_next.valid[1] & out_next[1])),
		.prefault     (PREFAULT)
	);

	assign START_OUT   = out_reg[`MJP_EV_START];
	assign TRIP_OUT    = out_reg[`MJP_EV_TRIP];
	assign BLOCKED_OUT = out_reg[`MJP_EV_BLOCK];
	assign EVENT       = evt_reg;
	assign EVENT_COUNT = cnt_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	a_inhibit_starting: assert property (@(posedge CLK) disable iff (!RSTN)
		MOTOR_STARTING |=> state_reg == mjp_pkg::MJP_IDLE) else $error("stage active while motor starting");
	a_instant_direct: assert property (@(posedge CLK) disable iff (!RSTN)
		state_reg == mjp_pkg::MJP_IDLE && act && pick_reg && !blk && grp.instant
		|=> state_reg == mjp_pkg::MJP_TRIP) else $error("instant mode did not trip at once");
	a_instant_pair: assert property (@(posedge CLK) disable iff (!RSTN)
		$rose(out_reg[0]) && $rose(out_reg[1]) |-> evt_reg.valid[1:0] == 2'b11 && evt_reg.on[1:0] == 2'b11)
		else $error("start and trip events not issued together");
	a_stamp_step: assert property (@(posedge CLK) disable iff (!RSTN)
		tick |=> stamp_reg == $past(stamp_reg) + 32'h0000_0001) else $error("stamp did not advance on tick");
	a_count_start: assert property (@(posedge CLK) disable iff (!RSTN)
		$rose(out_reg[0]) |-> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001) else $error("start counter missed");
	a_pickup_any: assert property (@(posedge CLK) disable iff (!RSTN)
		|over |=> pick_reg) else $error("pick-up missed");
	a_hold_hyst: assert property (@(posedge CLK) disable iff (!RSTN)
		pick_reg && !(&under) |=> pick_reg) else $error("pick-up released inside hysteresis");
	a_block_start: assert property (@(posedge CLK) disable iff (!RSTN)
		state_reg == mjp_pkg::MJP_START && act && pick_reg && blk |=> state_reg == mjp_pkg::MJP_BLOCK)
		else $error("start not replaced by blocked");
	a_drop_no_trip: assert property (@(posedge CLK) disable iff (!RSTN)
		state_reg == mjp_pkg::MJP_START && !pick_reg |=> state_reg == mjp_pkg::MJP_IDLE ##1 !out_reg[1])
		else $error("dropout before expiry tripped");
	a_force_block: assert property (@(posedge CLK) disable iff (!RSTN)
		FORCE_ENABLE && FORCE_STATUS == `MJP_FORCE_BLOCKED |=> out_reg == 3'b100) else $error("forcing ignored");

	c_instant_trip: cover property (@(posedge CLK) disable iff (!RSTN) $rose(out_reg[0]) && $rose(out_reg[1]));
	c_delay_trip: cover property (@(posedge CLK) disable iff (!RSTN) out_reg[0] && !out_reg[1] ##1 out_reg[1]);
	c_blocked: cover property (@(posedge CLK) disable iff (!RSTN) $rose(out_reg[2]));
	c_dropout: cover property (@(posedge CLK) disable iff (!RSTN) $fell(out_reg[0]) && !$past(out_reg[1]));
endmodule : mjp_jam_stage

// File: hdl/mjp_pkg.sv
// Types shared by the jam stage and its pre-fault recorder.
`include "mjp_cfg.svh"
package mjp_pkg;
	typedef logic [2:0][`MJP_MAG_W-1:0] mjp_phase_t;

	typedef struct packed {
		logic       valid;
		mjp_phase_t mag;
	} mjp_meas_t;

	typedef struct packed {
		logic [`MJP_MAG_W-1:0]   threshold;
		logic                    instant;
		logic [`MJP_DELAY_W-1:0] delay_ms;
	} mjp_group_t;

	typedef struct packed {
		logic [2:0]              valid;
		logic [2:0]              on;
		logic [`MJP_STAMP_W-1:0] stamp;
	} mjp_event_t;

	typedef enum logic [3:0] {
		MJP_IDLE  = 4'b0001,
		MJP_START = 4'b0010,
		MJP_TRIP  = 4'b0100,
		MJP_BLOCK = 4'b1000
	} mjp_state_t;
endpackage : mjp_pkg

// File: hdl/mjp_prefault.sv
// Pre-fault recorder: keeps 5 ms samples and averages the older 20 ms window.
`timescale 1ns/1ps
`include "mjp_cfg.svh"
module mjp_prefault (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rstn,
	// Samples and capture request
	input  wire logic               sample_valid,
	input  wire mjp_pkg::mjp_phase_t sample,
	input  wire logic               capture,
	// Captured average
	output mjp_pkg::mjp_phase_t     prefault
);
	mjp_pkg::mjp_phase_t hist_reg [`MJP_HIST_DEPTH];
	mjp_pkg::mjp_phase_t hist_next [`MJP_HIST_DEPTH];
	mjp_pkg::mjp_phase_t pre_reg;
	mjp_pkg::mjp_phase_t pre_next;
	mjp_pkg::mjp_phase_t avg;

	// Entries 0..3 hold the newest 20 ms, so 4..7 end 20 ms back.
	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_phase
			logic [`MJP_MAG_W+1:0] sum;
			always_comb begin
				sum = '0;
				for (int i = `MJP_AVG_DEPTH; i < `MJP_HIST_DEPTH; i++) begin
					sum = sum + {2'b00, hist_reg[i][p]};
				end
				avg[p] = sum[`MJP_MAG_W+1:`MJP_AVG_SHIFT];
			end
		end
	endgenerate

	always_comb begin
		for (int i = 0; i < `MJP_HIST_DEPTH; i++) begin
			hist_next[i] = hist_reg[i];
		end
		if (sample_valid) begin
			hist_next[0] = sample;
			for (int i = 1; i < `MJP_HIST_DEPTH; i++) begin
				hist_next[i] = hist_reg[i-1];
			end
		end
		pre_next = capture ? avg : pre_reg;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `MJP_HIST_DEPTH; i++) begin
				hist_reg[i] <= '0;
			end
			pre_reg <= '0;
		end else begin
			for (int i = 0; i < `MJP_HIST_DEPTH; i++) begin
				hist_reg[i] <= hist_next[i];
			end
			pre_reg <= pre_next;
		end
	end

	assign prefault = pre_reg;
endmodule : mjp_prefault

// File: tb/mjp_meas_src.sv
// Current measurement module model: periodic three-phase RMS samples.
`timescale 1ns/1ps
module mjp_meas_src #(
	parameter int PERIOD = 50
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rstn,
	// Magnitudes to publish
	input  wire mjp_pkg::mjp_phase_t level,
	// Sample stream
	output mjp_pkg::mjp_meas_t       meas
);
	int cnt_reg;
	always @(negedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg = 0;
			meas = '0;
		end else begin
			cnt_reg = (cnt_reg + 1) % PERIOD;
			meas.valid = (cnt_reg == 0);
			// Between samples the lines carry no data, so the inverse exposes any late latching.
			meas.mag = (cnt_reg == 0) ? level : ~level;
		end
	end
endmodule : mjp_meas_src

// File: tb/tb.sv
// Self-checking bench of the jam stage.
`timescale 1ns/1ps
`include "mjp_cfg.svh"
module tb;
	localparam int TICK = 10;
	localparam int SMP  = 5 * TICK;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	mjp_pkg::mjp_meas_t  cur_a, cur_b;
	mjp_pkg::mjp_phase_t lev_a = '0, lev_b = '0, prefault;
	logic run = 0, starting = 0, blk = 0, gwr = 0, lnen = 0, fen = 0, multi = 0;
	logic [2:0] gidx = 0, agrp = 0, ln = 3'h1;
	logic [1:0] fst = 0, msel = 2'h1;
	mjp_pkg::mjp_group_t gdat = '0;
	logic st, tr, bl;
	logic [2:0] outs;
	mjp_pkg::mjp_event_t ev, last_ev;
	logic [2:0][15:0] cnt, c0;
	logic [31:0] s_stamp, t_stamp;
	int err_count = 0;
	int samples_checked = 0;
	always #5 clk = ~clk;
	assign outs = {bl, tr, st};
	mjp_meas_src #(.PERIOD(SMP)) u_src_a (.clk(clk), .rstn(rstn), .level(lev_a), .meas(cur_a));
	mjp_meas_src #(.PERIOD(SMP)) u_src_b (.clk(clk), .rstn(rstn), .level(lev_b), .meas(cur_b));
	mjp_jam_stage #(.TICK_CYCLES(TICK)) u_dut (.CLK(clk), .RSTN(rstn), .CUR_FIRST(cur_a), .CUR_SECOND(cur_b),
		.MOTOR_RUNNING(run), .MOTOR_STARTING(starting), .BLOCK_IN(blk), .GRP_WR(gwr), .GRP_WR_IDX(gidx),
		.GRP_WR_DATA(gdat), .ACTIVE_GROUP(agrp), .LN_SET_ENABLE(lnen), .LN_STATE(ln), .FORCE_ENABLE(fen),
		.FORCE_STATUS(fst), .MEAS_SEL(msel), .MULTI_MODULE(multi), .START_OUT(st), .TRIP_OUT(tr),
		.BLOCKED_OUT(bl), .EVENT(ev), .EVENT_COUNT(cnt), .PREFAULT(prefault));
	// Event pulses last one cycle, so they are latched here.
	always @(posedge clk) begin
		if (ev.valid[0] === 1'b1 && ev.on[0] === 1'b1) s_stamp <= ev.stamp;
		if (ev.valid[1] === 1'b1 && ev.on[1] === 1'b1) t_stamp <= ev.stamp;
		if (ev.valid !== 3'b000) last_ev <= ev;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wait_bit(input int idx, input logic val, input int lim);
		int n;
		n = 0;
		while (n < lim && outs[idx] !== val) begin
			@(negedge clk);
			n++;
		end
		if (outs[idx] !== val) begin
			err_count++;
			$display("MISMATCH at %0t: output %0d timed out", $time, idx);
			close_out();
		end else begin
			// The event latch above updates one edge after the output, so let it land.
			@(negedge clk);
		end
	endtask : wait_bit
	task automatic wgrp(input int idx, input int thr, input logic inst, input int dly);
		@(negedge clk);
		gwr = 1'b1;
		gidx = idx[2:0];
		gdat = '{threshold: thr[15:0], instant: inst, delay_ms: dly[20:0]};
		@(negedge clk);
		gwr = 1'b0;
	endtask : wgrp
	task automatic settle(input string name);
		lev_a = '0;
		lev_b = '0;
		repeat (3 * SMP) @(negedge clk);
		chk(outs, 3'b000, "idle");
		$display("Test %s done", name);
	endtask : settle
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		chk({outs, cnt}, '0, "reset");
		wgrp(1, 100, 1'b0, 3);
		wgrp(2, 100, 1'b1, 0);
		wgrp(3, 100, 1'b0, 1000);
		agrp = 3'h1;
		run = 1'b1;
		starting = 1'b1;
		lev_a = {16'h00C8, 16'h0000, 16'h0000};
		repeat (3 * SMP) @(negedge clk);
		chk(outs, 3'b000, "inhibit while starting");
		starting = 1'b0;
		c0 = cnt;
		wait_bit(0, 1'b1, 3 * SMP);
		wait_bit(1, 1'b1, 6 * TICK);
		chk((t_stamp - s_stamp == 3) || (t_stamp - s_stamp == 4), 1'b1, "delay in ms");
		chk(cnt[1:0], {c0[1] + 16'h0001, c0[0] + 16'h0001}, "counters");
		settle("delayed trip");
		agrp = 3'h3;
		lev_a = {16'h0000, 16'h0064, 16'h0000};
		repeat (3 * SMP) @(negedge clk);
		chk(outs, 3'b000, "equal to threshold");
		lev_a = {16'h0000, 16'h0096, 16'h0000};
		wait_bit(0, 1'b1, 3 * SMP);
		lev_a = {16'h0000, 16'h0061, 16'h0000};
		repeat (3 * SMP) @(negedge clk);
		chk(outs, 3'b001, "hold at 97 percent");
		lev_a = {16'h0000, 16'h0060, 16'h0000};
		wait_bit(0, 1'b0, 3 * SMP);
		chk({last_ev.valid, last_ev.on, outs}, {3'b001, 3'b000, 3'b000}, "start off, no trip");
		settle("hysteresis");
		agrp = 3'h2;
		lev_a = {16'h001E, 16'h0014, 16'h000A};
		repeat (10 * SMP) @(negedge clk);
		lev_a = {16'h012C, 16'h0014, 16'h000A};
		wait_bit(1, 1'b1, 3 * SMP);
		chk({last_ev.valid, last_ev.on}, {3'b011, 3'b011}, "instant events");
		chk(s_stamp, t_stamp, "one stamp");
		chk(prefault, {16'h001E, 16'h0014, 16'h000A}, "pre-fault average");
		settle("instant");
		agrp = 3'h3;
		c0 = cnt;
		lev_a = {16'h012C, 16'h0000, 16'h0000};
		wait_bit(0, 1'b1, 3 * SMP);
		blk = 1'b1;
		wait_bit(2, 1'b1, 20);
		chk({outs, cnt[2] - c0[2]}, {3'b100, 16'h0001}, "blocked replaces start");
		lev_a = '0;
		blk = 1'b0;
		settle("blocking");
		lnen = 1'b1;
		for (int k = 1; k <= 5; k++) begin
			ln = k[2:0];
			lev_a = {16'h012C, 16'h0000, 16'h0000};
			repeat (3 * SMP) @(negedge clk);
			chk(outs, (k == 2 || k == 4) ? 3'b100 : (k == 5) ? 3'b000 : 3'b001, "node state");
			settle("node state");
		end
		lnen = 1'b0;
		multi = 1'b1;
		msel = 2'h2;
		lev_b = {16'h012C, 16'h0000, 16'h0000};
		wait_bit(0, 1'b1, 3 * SMP);
		multi = 1'b0;
		wait_bit(0, 1'b0, 3 * SMP);
		settle("module select");
		fen = 1'b1;
		for (int k = 0; k < 4; k++) begin
			fst = k[1:0];
			repeat (5) @(negedge clk);
			chk(outs, (k == 0) ? 3'b000 : (k == 1) ? 3'b001 : (k == 2) ? 3'b011 : 3'b100, "forced");
		end
		fen = 1'b0;
		settle("forcing");
		close_out();
	end
endmodule : tb
